// file: design/sram_async_regs.svh
// Register map, field positions, reset values and codes of the controller.
`ifndef SRAM_ASYNC_REGS_SVH
`define SRAM_ASYNC_REGS_SVH

`define REG_BANK_CONTROL 8'h00
`define REG_BANK_TIMING 8'h04
`define REG_BANK_WR_TIMING 8'h08
`define REG_STATUS 8'h0c

`define IDX_BANK_CONTROL 2'h0
`define IDX_BANK_TIMING 2'h1
`define IDX_BANK_WR_TIMING 2'h2
`define IDX_STATUS 2'h3

`define BC_WAIT_EN 15
`define BC_EXT_MODE 14
`define BC_WAIT_POL 9
`define BC_BURST_EN 8
`define BC_MEMORY_TYPE_HI 3
`define BC_MEMORY_TYPE_LO 2
`define BC_BANK_EN 0
`define MEMORY_TYPE_NOR 2'h2

`define BT_DATA_PHASE_LEN_HI 15
`define BT_DATA_PHASE_LEN_LO 8
`define BT_ADDR_PHASE_LEN_HI 3
`define BT_ADDR_PHASE_LEN_LO 0

`define BC_RESET 32'h0000_0011
`define BT_RESET 32'h0000_ff0f
`define BC_WMASK 32'h0000_c37f
`define BT_WMASK 32'h3000_ff0f

`define ST_BUSY 0
`define ST_ERROR 1

`define LANES_ALL 2'h0
`define LANES_NONE 2'h3
`define LANE_LOW 2'h2
`define LANE_UP 2'h1

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: design/sram_async_pkg.sv
// Types shared by the static memory access controller.
package sram_async_pkg;
    typedef enum logic [1:0] {
        SZ_BYTE = 2'b00,
        SZ_HALF = 2'b01,
        SZ_WORD = 2'b10,
        SZ_BAD = 2'b11
    } xfer_size_t;

    typedef struct packed {
        logic write;
        xfer_size_t size;
        logic [26:0] addr;
        logic [31:0] wdata;
    } host_req_t;

    typedef struct packed {
        logic [25:0] addr;
        logic [15:0] dout;
        logic dout_en;
        logic chip_select_n;
        logic output_enable_n;
        logic write_strobe_n;
        logic [1:0] byte_lane_n;
    } mem_pins_t;

    typedef struct packed {
        logic [3:0] addr_phase_len;
        logic [7:0] data_phase_len;
        logic async_wait_en;
        logic wait_polarity;
    } phase_cfg_t;

    typedef enum logic [1:0] {
        E_IDLE = 2'b00,
        E_ADDR = 2'b01,
        E_DATA = 2'b10,
        E_HOLD = 2'b11
    } eng_state_t;

    typedef enum logic [1:0] {
        T_IDLE = 2'b00,
        T_FIRST = 2'b01,
        T_SECOND = 2'b10,
        T_RESP = 2'b11
    } ctrl_state_t;
endpackage

// file: design/access_phase_engine.sv
// Sequencer for one 16-bit two-phase asynchronous memory access.
`timescale 1ns/1ps
`include "sram_async_regs.svh"
module access_phase_engine
    import sram_async_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_int_n,
    input wire logic start,
    input wire logic start_write,
    input wire logic [25:0] start_addr,
    input wire logic [15:0] start_wdata,
    input wire logic [1:0] start_lanes_n,
    input wire phase_cfg_t cfg,
    input wire logic [15:0] mem_din,
    input wire logic wait_in_n,
    output mem_pins_t pins,
    output logic done,
    output logic [15:0] rdata
);
    eng_state_t state_r;
    logic [7:0] cnt_r;
    logic write_r;
    logic wr;
    logic wait_hold;
    logic go_data;
    logic end_data;
    logic [7:0] data_len;

    // Polarity only matters once waiting is enabled.
    assign wait_hold = cfg.async_wait_en &&
        (wait_in_n == cfg.wait_polarity);
    assign wr = (state_r == E_IDLE) ? start_write : write_r;
    // A zero data phase is stretched to one cycle to keep strobes visible.
    assign data_len = (cfg.data_phase_len == 8'h00) ? 8'h01 :
        cfg.data_phase_len;
    assign go_data = (state_r == E_IDLE && start &&
        cfg.addr_phase_len == 4'h0) ||
        (state_r == E_ADDR && cnt_r == 8'h00);
    assign end_data = state_r == E_DATA && cnt_r == 8'h00 &&
        !wait_hold;

    // Address phase first, then data phase; writes add a hold cycle.
    always_ff @(posedge clk_sys or negedge rst_int_n) begin
        if (!rst_int_n) begin
            state_r <= E_IDLE;
            cnt_r <= 8'h00;
            write_r <= 1'b0;
        end else begin
            unique case (state_r)
                E_IDLE: begin
                    if (start) begin
                        write_r <= start_write;
                        if (go_data) begin
                            state_r <= E_DATA;
                            cnt_r <= data_len - 8'h01;
                        end else begin
                            state_r <= E_ADDR;
                            cnt_r <= {4'h0, cfg.addr_phase_len} - 8'h01;
                        end
                    end
                end
                E_ADDR: begin
                    if (go_data) begin
                        state_r <= E_DATA;
                        cnt_r <= data_len - 8'h01;
                    end else begin
                        cnt_r <= cnt_r - 8'h01;
                    end
                end
                E_DATA: begin
                    if (end_data) begin
                        state_r <= write_r ? E_HOLD : E_IDLE;
                    end else if (cnt_r != 8'h00) begin
                        cnt_r <= cnt_r - 8'h01;
                    end
                end
                E_HOLD: begin
                    state_r <= E_IDLE;
                end
            endcase
        end
    end

    // Pins change only here, on the rising system clock edge.
    always_ff @(posedge clk_sys or negedge rst_int_n) begin
        if (!rst_int_n) begin
            pins.addr <= 26'h0;
            pins.dout <= 16'h0;
            pins.dout_en <= 1'b0;
            pins.chip_select_n <= 1'b1;
            pins.output_enable_n <= 1'b1;
            pins.write_strobe_n <= 1'b1;
            pins.byte_lane_n <= `LANES_NONE;
            done <= 1'b0;
            rdata <= 16'h0;
        end else begin
            done <= (end_data && !write_r) || state_r == E_HOLD;
            if (state_r == E_IDLE && start) begin
                pins.chip_select_n <= 1'b0;
                pins.addr <= start_addr;
                pins.dout <= start_wdata;
                pins.dout_en <= start_write;
                // Reads keep both lanes enabled.
                pins.byte_lane_n <= start_write ? start_lanes_n :
                    `LANES_ALL;
            end
            if (go_data) begin
                if (wr) begin
                    pins.write_strobe_n <= 1'b0;
                end else begin
                    pins.output_enable_n <= 1'b0;
                end
            end
            if (end_data) begin
                if (write_r) begin
                    pins.write_strobe_n <= 1'b1;
                end else begin
                    // Data is taken on the edge that releases the select.
                    rdata <= mem_din;
                    pins.output_enable_n <= 1'b1;
                    pins.chip_select_n <= 1'b1;
                    pins.byte_lane_n <= `LANES_NONE;
                end
            end
            if (state_r == E_HOLD) begin
                pins.chip_select_n <= 1'b1;
                pins.dout_en <= 1'b0;
                pins.byte_lane_n <= `LANES_NONE;
            end
        end
    end
endmodule

// file: design/static_memory_async_ctrl.sv
// Asynchronous static memory controller with an AXI4-Lite register slave.
// Operation
// - Word transfers become two halfword accesses.
// - Never generate asynchronous page reads.
// - Byte write enables only the addressed lane.
// - Refuse byte NOR writes, byte burst reads.
// - Memory outputs change on rising clock only.
// - Synchronous output data moves on falling edge.
// - Asynchronous accesses drive no memory clock.
// - Capture read data before releasing select.
// - Extended mode gives writes separate timing.
// - Writes end with one stable hold cycle.
// - Data phase: length plus one write, length read.
// - Address phase lasts its length, zero allowed.
// - Wait polarity matters only when waiting enabled.
// - Reads hold both lane enables low.
// - N-prefixed memory controls are active low.
//
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "sram_async_regs.svh"
module static_memory_async_ctrl
    import sram_async_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic host_req_valid,
    input wire host_req_t host_req,
    output logic host_req_ready,
    output logic host_resp_valid,
    output logic host_resp_error,
    output logic [31:0] host_resp_rdata,
    output mem_pins_t mem_pins,
    input wire logic [15:0] mem_din,
    input wire logic wait_in_n,
    output logic memory_clock
);
    if (ADDR_W < 8) begin : g_addr_check
        $error("ADDR_W must be at least 8");
    end

    logic rst_meta_r;
    logic rst_int_n;
    logic [31:0] bank_control_r;
    logic [31:0] bank_timing_r;
    logic [31:0] bank_wr_timing_r;
    logic error_r;
    logic [ADDR_W-1:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic do_write;
    logic [2:0] wsel;
    logic [2:0] rsel;
    logic err_set;
    ctrl_state_t state_r;
    host_req_t req_r;
    logic [15:0] low_half_r;
    logic eng_start_r;
    logic eng_write_r;
    logic [25:0] eng_addr_r;
    logic [15:0] eng_wdata_r;
    logic [1:0] eng_lanes_r;
    logic eng_done;
    logic [15:0] eng_rdata;
    phase_cfg_t cfg;
    logic [31:0] cfg_src;
    logic req_take;

    // Returns {hit, index} for a byte address.
    function automatic logic [2:0] reg_decode(input logic [7:0] a);
        unique case (a)
            `REG_BANK_CONTROL: reg_decode = {1'b1, `IDX_BANK_CONTROL};
            `REG_BANK_TIMING: reg_decode = {1'b1, `IDX_BANK_TIMING};
            `REG_BANK_WR_TIMING: reg_decode = {1'b1, `IDX_BANK_WR_TIMING};
            `REG_STATUS: reg_decode = {1'b1, `IDX_STATUS};
            default: reg_decode = 3'h0;
        endcase
    endfunction

    // Applies byte strobes and the writable-bit mask to a register.
    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] din, input logic [3:0] strb,
        input logic [31:0] wmask);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        m = m & wmask;
        merge = (old & ~m) | (din & m);
    endfunction

    // Transfers this mode cannot serve are answered with an error.
    function automatic logic refused(input host_req_t r,
        input logic [31:0] bc);
        logic nor_type;
        nor_type = bc[`BC_MEMORY_TYPE_HI:`BC_MEMORY_TYPE_LO] == `MEMORY_TYPE_NOR;
        refused = !bc[`BC_BANK_EN] || r.size == SZ_BAD ||
            (r.size == SZ_BYTE && r.write && nor_type) ||
            (r.size == SZ_BYTE && !r.write && bc[`BC_BURST_EN]);
    endfunction

    // Selects the byte-lane enables, active low.
    function automatic logic [1:0] lanes_for(input xfer_size_t sz,
        input logic a0);
        if (sz == SZ_BYTE) begin
            lanes_for = a0 ? `LANE_UP : `LANE_LOW;
        end else begin
            lanes_for = `LANES_ALL;
        end
    endfunction

    // Reset is released through two flip-flops.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_r <= 1'b0;
            rst_int_n <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_int_n <= rst_meta_r;
        end
    end

    // No memory clock is driven; only asynchronous accesses exist.
    always_ff @(posedge clk_sys or negedge rst_int_n) begin
        if (!rst_int_n) begin
            memory_clock <= 1'b0;
        end else begin
            memory_clock <= 1'b0;
        end
    end

    assign wsel = reg_decode(aw_addr_r[7:0]);
    assign rsel = reg_decode(s_axi_araddr[7:0]);
    assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

    // Write address and data are taken in either order, then answered.
    always_ff @(posedge clk_sys or negedge rst_int_n) begin
        if (!rst_int_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            aw_addr_r <= '0;
            w_data_r <= 32'h0;
            w_strb_r <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_r <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wsel[2] ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Configuration registers.
    always_ff @(posedge clk_sys or negedge rst_int_n) begin
        if (!rst_int_n) begin
            bank_control_r <= `BC_RESET;
            bank_timing_r <= `BT_RESET;
            bank_wr_timing_r <= `BT_RESET;
        end else if (do_write && wsel[2]) begin
            unique case (wsel[1:0])
                `IDX_BANK_CONTROL: begin
                    bank_control_r <= merge(bank_control_r, w_data_r,
                        w_strb_r, `BC_WMASK);
                end
                `IDX_BANK_TIMING: begin
                    bank_timing_r <= merge(bank_timing_r, w_data_r,
                        w_strb_r, `BT_WMASK);
                end
                `IDX_BANK_WR_TIMING: begin
                    bank_wr_timing_r <= merge(bank_wr_timing_r, w_data_r,
                        w_strb_r, `BT_WMASK);
                end
                `IDX_STATUS: begin
                end
            endcase
        end
    end

    // Sticky refusal flag; a new refusal wins over a clearing write.
    always_ff @(posedge clk_sys or negedge rst_int_n) begin
        if (!rst_int_n) begin
            error_r <= 1'b0;
        end else if (err_set) begin
            error_r <= 1'b1;
        end else if (do_write && wsel == {1'b1, `IDX_STATUS} &&
            w_strb_r[0] && w_data_r[`ST_ERROR]) begin
            error_r <= 1'b0;
        end
    end

    // Register reads, one at a time.
    always_ff @(posedge clk_sys or negedge rst_int_n) begin
        if (!rst_int_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= rsel[2] ? `RESP_OKAY : `RESP_SLVERR;
            s_axi_rdata <= 32'h0;
            if (rsel[2]) begin
                unique case (rsel[1:0])
                    `IDX_BANK_CONTROL: s_axi_rdata <= bank_control_r;
                    `IDX_BANK_TIMING: s_axi_rdata <= bank_timing_r;
                    `IDX_BANK_WR_TIMING: s_axi_rdata <= bank_wr_timing_r;
                    `IDX_STATUS: begin
                        s_axi_rdata[`ST_BUSY] <= !host_req_ready;
                        s_axi_rdata[`ST_ERROR] <= error_r;
                    end
                endcase
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Extended mode lets writes run on their own timing register.
    assign cfg_src = (eng_write_r && bank_control_r[`BC_EXT_MODE]) ?
        bank_wr_timing_r : bank_timing_r;
    assign cfg.addr_phase_len = cfg_src[`BT_ADDR_PHASE_LEN_HI:`BT_ADDR_PHASE_LEN_LO];
    assign cfg.data_phase_len = cfg_src[`BT_DATA_PHASE_LEN_HI:`BT_DATA_PHASE_LEN_LO];
    assign cfg.async_wait_en = bank_control_r[`BC_WAIT_EN];
    assign cfg.wait_polarity = bank_control_r[`BC_WAIT_POL];

    assign req_take = host_req_valid && host_req_ready;
    assign err_set = req_take && refused(host_req, bank_control_r);

    // Host transfer sequencer; only single accesses, never page reads.
    always_ff @(posedge clk_sys or negedge rst_int_n) begin
        if (!rst_int_n) begin
            state_r <= T_IDLE;
            req_r <= '0;
            host_req_ready <= 1'b1;
            eng_start_r <= 1'b0;
            eng_write_r <= 1'b0;
            eng_addr_r <= 26'h0;
            eng_wdata_r <= 16'h0;
            eng_lanes_r <= `LANES_ALL;
        end else begin
            eng_start_r <= 1'b0;
            unique case (state_r)
                T_IDLE: begin
                    if (req_take) begin
                        req_r <= host_req;
                        host_req_ready <= 1'b0;
                        if (err_set) begin
                            state_r <= T_RESP;
                        end else begin
                            state_r <= T_FIRST;
                            eng_start_r <= 1'b1;
                            eng_write_r <= host_req.write;
                            eng_addr_r <= host_req.addr[26:1];
                            eng_wdata_r <= host_req.wdata[15:0];
                            eng_lanes_r <= lanes_for(host_req.size,
                                host_req.addr[0]);
                        end
                    end
                end
                T_FIRST: begin
                    if (eng_done && req_r.size == SZ_WORD) begin
                        state_r <= T_SECOND;
                        eng_start_r <= 1'b1;
                        eng_addr_r <= eng_addr_r + 26'h1;
                        eng_wdata_r <= req_r.wdata[31:16];
                    end else if (eng_done) begin
                        state_r <= T_RESP;
                    end
                end
                T_SECOND: begin
                    if (eng_done) begin
                        state_r <= T_RESP;
                    end
                end
                T_RESP: begin
                    state_r <= T_IDLE;
                    host_req_ready <= 1'b1;
                end
            endcase
        end
    end

    // Answer to the host: one pulse with data or an error.
    always_ff @(posedge clk_sys or negedge rst_int_n) begin
        if (!rst_int_n) begin
            low_half_r <= 16'h0;
            host_resp_valid <= 1'b0;
            host_resp_error <= 1'b0;
            host_resp_rdata <= 32'h0;
        end else begin
            host_resp_valid <= 1'b0;
            if (state_r == T_FIRST && eng_done) begin
                low_half_r <= eng_rdata;
            end
            if (state_r == T_IDLE && err_set) begin
                host_resp_valid <= 1'b1;
                host_resp_error <= 1'b1;
                host_resp_rdata <= 32'h0;
            end else if (eng_done && (state_r == T_SECOND ||
                (state_r == T_FIRST && req_r.size != SZ_WORD))) begin
                host_resp_valid <= 1'b1;
                host_resp_error <= 1'b0;
                host_resp_rdata <= (state_r == T_SECOND) ?
                    {eng_rdata, low_half_r} : {16'h0, eng_rdata};
            end
        end
    end

    // Active-low memory controls come from the engine's flip-flops.
    access_phase_engine u_engine (
        .clk_sys(clk_sys),
        .rst_int_n(rst_int_n),
        .start(eng_start_r),
        .start_write(eng_write_r),
        .start_addr(eng_addr_r),
        .start_wdata(eng_wdata_r),
        .start_lanes_n(eng_lanes_r),
        .cfg(cfg),
        .mem_din(mem_din),
        .wait_in_n(wait_in_n),
        .pins(mem_pins),
        .done(eng_done),
        .rdata(eng_rdata)
    );
endmodule

// file: test/static_memory_async_ctrl_sva.sv
// Pin and handshake checks for the static memory controller.
`timescale 1ns/1ps
module static_memory_async_ctrl_sva
    import sram_async_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic host_req_valid,
    input wire host_req_t host_req,
    input wire logic host_req_ready,
    input wire logic host_resp_valid,
    input wire logic host_resp_error,
    input wire mem_pins_t mem_pins,
    input wire logic memory_clock
);
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    a_no_mem_clock: assert property (!memory_clock)
        else $error("memory clock driven");
    a_read_lanes_low: assert property (
        !mem_pins.output_enable_n |-> mem_pins.byte_lane_n == 2'h0)
        else $error("read lanes not low");
    a_strobe_in_select: assert property (
        !mem_pins.output_enable_n || !mem_pins.write_strobe_n
        |-> !mem_pins.chip_select_n)
        else $error("strobe outside select");
    a_write_hold: assert property (
        $rose(mem_pins.write_strobe_n) |-> !mem_pins.chip_select_n
        && $stable(mem_pins.addr) && $stable(mem_pins.dout)
        ##1 mem_pins.chip_select_n)
        else $error("no write hold cycle");
    a_bus_no_clash: assert property (
        !mem_pins.output_enable_n
        |-> !mem_pins.dout_en && mem_pins.write_strobe_n)
        else $error("read overlaps write");
    a_write_lanes_on: assert property (
        !mem_pins.write_strobe_n
        |-> mem_pins.byte_lane_n != 2'h3 && mem_pins.dout_en)
        else $error("write without lanes");
    a_bad_size_refused: assert property (
        host_req_valid && host_req_ready && host_req.size == SZ_BAD
        |=> host_resp_valid && host_resp_error)
        else $error("bad size not refused");
    a_resp_pulse: assert property (
        host_resp_valid
        |-> !host_req_ready ##1 !host_resp_valid && host_req_ready)
        else $error("response not one pulse");
endmodule

bind static_memory_async_ctrl static_memory_async_ctrl_sva sva_u (
    .clk_sys, .rst_n, .host_req_valid, .host_req, .host_req_ready,
    .host_resp_valid, .host_resp_error, .mem_pins, .memory_clock);

// file: test/sram_mem_model.sv
// Behavioural 16-bit static memory with an optional wait output.
`timescale 1ns/1ps
module sram_mem_model
    import sram_async_pkg::*;
(
    input wire logic clk_sys,
    input wire mem_pins_t mem_pins,
    input wire logic [3:0] stall,
    output logic [15:0] mem_din,
    output logic wait_in_n
);
    logic [15:0] mem [16];
    logic [15:0] last_r = 16'h0;
    logic [3:0] cnt_r = 4'h0;
    logic [3:0] a;
    assign a = mem_pins.addr[3:0];
    // Unselected bus shows a changing pattern, never the last value.
    assign mem_din = (!mem_pins.chip_select_n && !mem_pins.output_enable_n)
        ? mem[a] : ~last_r;
    assign wait_in_n = (cnt_r == 4'h0) || mem_pins.chip_select_n;
    always_ff @(posedge clk_sys) begin
        last_r <= mem_din;
        cnt_r <= mem_pins.chip_select_n ? stall
            : cnt_r - {3'h0, cnt_r != 4'h0};
        if (!mem_pins.chip_select_n && !mem_pins.write_strobe_n) begin
            if (!mem_pins.byte_lane_n[0])
                mem[a][7:0] <= mem_pins.dout[7:0];
            if (!mem_pins.byte_lane_n[1])
                mem[a][15:8] <= mem_pins.dout[15:8];
        end
    end
endmodule

// file: test/static_memory_async_ctrl_tb.sv
// Self-checking bench for the static memory controller.
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; \
    $display("Error at %0t: got %h want %h", $time, a, b); end end
module static_memory_async_ctrl_tb;
    import sram_async_pkg::*;
    logic clk_sys = 0, rst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic host_req_valid = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, host_req_ready, host_resp_valid;
    logic host_resp_error, memory_clock, wait_in_n;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, host_resp_rdata;
    logic [3:0] s_axi_wstrb = 4'hf, stall = 0;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [15:0] mem_din;
    host_req_t host_req = '0;
    mem_pins_t mem_pins;
    int mismatches = 0, num_checks = 0;
    static_memory_async_ctrl dut_u (.*);
    sram_mem_model mem_u (.*);
    always #2 clk_sys = ~clk_sys;
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        `CHK(s_axi_bresp, {a > 8'h0c, 1'b0})
    endtask
    task automatic axr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        `CHK(s_axi_rdata, d)
        `CHK(s_axi_rresp, {a > 8'h0c, 1'b0})
    endtask
    task automatic hx(input logic w, input xfer_size_t sz,
            input logic [26:0] a, input logic [31:0] d, input logic e,
            input int lat);
        int n;
        @(posedge clk_sys);
        host_req <= '{w, sz, a, d};
        host_req_valid <= 1'b1;
        do @(posedge clk_sys); while (!host_req_ready);
        host_req_valid <= 1'b0;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (!host_resp_valid && n < 99);
        `CHK(host_resp_error, e)
        if (!w && !e)
            `CHK(host_resp_rdata, d)
        `CHK(n, lat)
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #20000;
        mismatches++;
        tally_and_finish();
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        axr(8'h00, 32'h11);
        axr(8'h08, 32'hff0f);
        axr(8'h10, 32'h0);
        axw(8'h10, 32'h1);
        axw(8'h04, 32'hffff_ffff);
        axr(8'h04, 32'h3000_ff0f);
        $display("registers done");
        axw(8'h04, 32'h0201);
        hx(1, SZ_HALF, 27'h0, 32'hffff, 0, 7);
        hx(0, SZ_HALF, 27'h0, 32'hffff, 0, 6);
        axw(8'h04, 32'h0100);
        hx(1, SZ_BYTE, 27'h1, 32'h3c00, 0, 5);
        hx(1, SZ_BYTE, 27'h0, 32'h0011, 0, 5);
        hx(0, SZ_BYTE, 27'h0, 32'h3c11, 0, 4);
        hx(1, SZ_WORD, 27'h4, 32'h1234_5678, 0, 9);
        `CHK(mem_u.mem[3], 16'h1234)
        hx(0, SZ_WORD, 27'h4, 32'h1234_5678, 0, 7);
        $display("timing done");
        hx(0, SZ_BAD, 27'h0, 32'h0, 1, 1);
        axw(8'h00, 32'h19);
        hx(1, SZ_BYTE, 27'h0, 32'h77, 1, 1);
        hx(1, SZ_HALF, 27'h6, 32'h4321, 0, 5);
        axw(8'h00, 32'h111);
        hx(0, SZ_BYTE, 27'h0, 32'h0, 1, 1);
        axr(8'h0c, 32'h2);
        axw(8'h0c, 32'h2);
        axr(8'h0c, 32'h0);
        $display("refusals done");
        axw(8'h00, 32'h4011);
        axw(8'h08, 32'h0300);
        hx(1, SZ_HALF, 27'h8, 32'h0abc, 0, 7);
        hx(0, SZ_HALF, 27'h8, 32'h0abc, 0, 4);
        stall <= 4'h3;
        axw(8'h00, 32'h0211);
        hx(0, SZ_HALF, 27'h8, 32'h0abc, 0, 4);
        axw(8'h00, 32'h8011);
        hx(0, SZ_HALF, 27'h8, 32'h0abc, 0, 7);
        $display("wait done");
        tally_and_finish();
    end
endmodule
